/* hdl/switch_port_ctrl_defines.svh */
// constants for the host-port control and statistics readout block
// assumes a plain register port, one clock, synchronous active-high reset
//
// What this block does
// R1 - learning-disable bit set stops source address learning on the host port
// R2 - bit 7, reset 0, makes the port the mirror destination for monitored packets
// R3 - bit 6, reset 0, marks every received packet monitored and mirrors it
// R4 - bit 5, reset 0, marks every transmitted packet monitored and mirrors it
// R5 - bit 3 caps packet priority at the port default tag priority
// R6 - bits 2:0 reset 0x7: membership mask, bit2 host, bit1 port 2, bit0 port 1
// R7 - traffic from this port goes only to ports included in the mask
// R8 - statistics counters are kept for each ethernet port
// R9 - counter word bit 31 is the read-only overflow flag, reset 0
// R10 - counter word bit 30 is the read-only count-valid flag, reset 0
// R11 - counter word bits 29:0 hold the count, reset 0, cleared by reading
// R12 - port 1 counters sit at indirect offsets 0x00 to 0x1f
// R13 - port 2 counters sit at indirect offsets 0x20 to 0x3f
// R14 - indirect read returns low half in one data register, high half in another
// R15 - read-clear also clears overflow; both halves come from one snapshot
`ifndef SWITCH_PORT_CTRL_DEFINES_SVH
`define SWITCH_PORT_CTRL_DEFINES_SVH

// ********************************************************************
// register offsets
// ********************************************************************
`define OFS_HOST_PORT_CTRL_TWO      8'h02
`define OFS_HOST_PORT_VLAN_ID_CTRL  8'h04
`define OFS_HOST_PORT_CTRL_THREE    8'h06
`define OFS_HOST_PORT_INGRESS_RATE  8'h08
`define OFS_HOST_PORT_EGRESS_RATE   8'h0a
`define OFS_BANK_SELECT             8'h0e
`define OFS_INDIRECT_ACCESS_CTRL    8'h10
`define OFS_INDIRECT_DATA_LOW_HALF  8'h12
`define OFS_INDIRECT_DATA_HIGH_HALF 8'h14
`define OFS_IRQ_STATUS              8'h16
`define OFS_IRQ_CLEAR               8'h18
`define OFS_IRQ_ENABLE              8'h1a

// ********************************************************************
// fields and reset values
// ********************************************************************
`define CTRL_TWO_RESET      16'h0607
`define CTRL_TWO_WR_MASK    16'h67ff
`define BIT_LEARN_DISABLE   8
`define BIT_MIRROR_DEST     7
`define BIT_RX_SNIFF        6
`define BIT_TX_SNIFF        5
`define BIT_PRIO_CEILING    3
`define IND_READ_BIT        12
`define IND_ADDR_W          10
`define CNT_PER_PORT        32
`define NUM_PORTS           2
`define IRQ_BIT_READ_DONE   0
`define IRQ_BIT_OVERFLOW    1

`endif

/* hdl/switch_port_ctrl_pkg.sv */
// types shared by the host-port control block
// assumes nothing of its surroundings
`default_nettype none
package switch_port_ctrl_pkg;
  typedef logic [15:0] reg16_type;
  typedef logic [7:0]  reg_addr_type;
  typedef struct packed {
    logic        overflow;
    logic        valid;
    logic [29:0] count;
  } counter_word_type;
endpackage : switch_port_ctrl_pkg
`default_nettype wire

/* hdl/switch_port_ctrl_mib_readout.sv */
// host-port control register bank and per-port statistics counters
// assumes count pulses and packet strobes come from logic on i_sys_clk
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "switch_port_ctrl_defines.svh"
`default_nettype none
module switch_port_ctrl_mib_readout #(
  parameter int NUM_CNT = `CNT_PER_PORT * `NUM_PORTS
) (
  input  wire logic                              i_sys_clk,
  input  wire logic                              i_rst,
  input  wire switch_port_ctrl_pkg::reg_addr_type i_addr,
  input  wire switch_port_ctrl_pkg::reg16_type    i_wdata,
  input  wire logic                              i_wr,
  input  wire logic                              i_rd,
  output logic [15:0]                            o_rdata,
  input  wire logic [NUM_CNT-1:0]                i_cnt_inc,
  input  wire logic                              i_rx_pkt,
  input  wire logic                              i_tx_pkt,
  input  wire logic [2:0]                        i_pkt_prio,
  input  wire logic [2:0]                        i_default_prio,
  input  wire logic [2:0]                        i_fwd_req,
  output logic                                   o_learn_enable,
  output logic                                   o_mirror_dest,
  output logic                                   o_rx_monitored,
  output logic                                   o_tx_monitored,
  output logic [2:0]                             o_pkt_prio,
  output logic [2:0]                             o_fwd_mask,
  output logic                                   o_irq
);
  import switch_port_ctrl_pkg::*;

  // ******************************************************************
  // register storage
  // ******************************************************************
  reg16_type                 ctrl_two_q;
  reg16_type                 vlan_id_q;
  reg16_type                 ctrl_three_q;
  reg16_type                 ingress_q;
  reg16_type                 egress_q;
  reg16_type                 bank_q;
  logic [`IND_ADDR_W-1:0]    ind_addr_q;
  counter_word_type          snap_q;
  logic [1:0]                irq_stat_q;
  logic [1:0]                irq_en_q;
  logic [15:0]               rdata_q;
  logic                      rx_mark_q;
  logic                      tx_mark_q;
  logic [2:0]                prio_q;
  logic [2:0]                fwd_q;
  logic [29:0]               cnt_q  [NUM_CNT];
  logic [NUM_CNT-1:0]        ovf_q;

  logic                      wr_ctrl_two;
  logic                      rd_trigger;
  logic                      in_window;
  logic [5:0]                rd_idx;
  logic                      any_wrap;
  logic [NUM_CNT-1:0]        wrap_vec;
  counter_word_type          word_now;

  assign wr_ctrl_two = i_wr && (i_addr == `OFS_HOST_PORT_CTRL_TWO);
  assign rd_trigger  = i_wr && (i_addr == `OFS_INDIRECT_ACCESS_CTRL)
                       && i_wdata[`IND_READ_BIT];
  // only the two per-port windows map to counters [R12] [R13]
  assign in_window   = (i_wdata[`IND_ADDR_W-1:0] < 10'(NUM_CNT));
  assign rd_idx      = i_wdata[5:0];

  // ******************************************************************
  // control registers
  // ******************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      ctrl_two_q <= `CTRL_TWO_RESET; // [R2] [R3] [R4] [R5] [R6]
    end
    else if (wr_ctrl_two)
    begin
      ctrl_two_q <= i_wdata & `CTRL_TWO_WR_MASK;
    end
  end

  // referenced registers hold their value only; their behaviour lives elsewhere
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      vlan_id_q    <= 16'h0000;
      ctrl_three_q <= 16'h0000;
      ingress_q    <= 16'h0000;
      egress_q     <= 16'h0000;
      bank_q       <= 16'h0000;
    end
    else if (i_wr)
    begin
      case (i_addr)
        `OFS_HOST_PORT_VLAN_ID_CTRL: vlan_id_q    <= i_wdata;
        `OFS_HOST_PORT_CTRL_THREE:   ctrl_three_q <= i_wdata;
        `OFS_HOST_PORT_INGRESS_RATE: ingress_q    <= i_wdata;
        `OFS_HOST_PORT_EGRESS_RATE:  egress_q     <= i_wdata;
        `OFS_BANK_SELECT:            bank_q       <= i_wdata;
        default:                     bank_q       <= bank_q;
      endcase
    end
  end

  assign o_learn_enable = ~ctrl_two_q[`BIT_LEARN_DISABLE]; // [R1]
  assign o_mirror_dest  = ctrl_two_q[`BIT_MIRROR_DEST];    // [R2]

  // ******************************************************************
  // packet path decisions
  // ******************************************************************
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      rx_mark_q <= 1'b0;
      tx_mark_q <= 1'b0;
    end
    else
    begin
      rx_mark_q <= i_rx_pkt && ctrl_two_q[`BIT_RX_SNIFF]; // [R3]
      tx_mark_q <= i_tx_pkt && ctrl_two_q[`BIT_TX_SNIFF]; // [R4]
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      prio_q <= 3'h0;
    end
    else if (ctrl_two_q[`BIT_PRIO_CEILING] && (i_pkt_prio > i_default_prio))
    begin
      prio_q <= i_default_prio; // [R5]
    end
    else
    begin
      prio_q <= i_pkt_prio;
    end
  end

  // a monitored packet also goes to the mirror port, chosen outside
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      fwd_q <= 3'h0;
    end
    else
    begin
      fwd_q <= i_fwd_req & ctrl_two_q[2:0]; // [R6] [R7]
    end
  end

  assign o_rx_monitored = rx_mark_q;
  assign o_tx_monitored = tx_mark_q;
  assign o_pkt_prio     = prio_q;
  assign o_fwd_mask     = fwd_q;

  // ******************************************************************
  // statistics counters
  // ******************************************************************
  // a count pulse in the clearing cycle survives as a count of one
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      for (int i = 0; i < NUM_CNT; i++)
      begin
        cnt_q[i] <= 30'h0; // [R11]
        ovf_q[i] <= 1'b0;  // [R9]
      end
    end
    else
    begin
      for (int i = 0; i < NUM_CNT; i++)
      begin
        if (rd_trigger && in_window && (rd_idx == 6'(i)))
        begin
          cnt_q[i] <= {29'h0, i_cnt_inc[i]}; // [R11] [R15]
          ovf_q[i] <= wrap_vec[i];
        end
        else if (i_cnt_inc[i])
        begin
          cnt_q[i] <= cnt_q[i] + 30'h1; // [R8]
          ovf_q[i] <= ovf_q[i] | wrap_vec[i]; // [R9]
        end
      end
    end
  end

  always_comb
  begin
    for (int i = 0; i < NUM_CNT; i++)
    begin
      wrap_vec[i] = i_cnt_inc[i] && (cnt_q[i] == 30'h3fffffff);
    end
  end
  assign any_wrap = |wrap_vec;

  always_comb
  begin
    word_now = '0;
    if (in_window)
    begin
      word_now.overflow = ovf_q[rd_idx]; // [R9]
      word_now.valid    = 1'b1;          // [R10]
      word_now.count    = cnt_q[rd_idx]; // [R11]
    end
  end

  // one snapshot feeds both halves so they never tear [R15]
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      snap_q <= '0; // [R10]
    end
    else if (rd_trigger)
    begin
      snap_q <= word_now; // [R14]
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      ind_addr_q <= 10'h000;
    end
    else if (i_wr && (i_addr == `OFS_INDIRECT_ACCESS_CTRL))
    begin
      ind_addr_q <= i_wdata[`IND_ADDR_W-1:0];
    end
  end

  // ******************************************************************
  // interrupts
  // ******************************************************************
  // set beats clear so no event is lost
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      irq_stat_q <= 2'h0;
    end
    else
    begin
      irq_stat_q[`IRQ_BIT_READ_DONE] <= rd_trigger ||
        (irq_stat_q[`IRQ_BIT_READ_DONE] &&
         !(i_wr && (i_addr == `OFS_IRQ_CLEAR) && i_wdata[`IRQ_BIT_READ_DONE]));
      irq_stat_q[`IRQ_BIT_OVERFLOW] <= any_wrap ||
        (irq_stat_q[`IRQ_BIT_OVERFLOW] &&
         !(i_wr && (i_addr == `OFS_IRQ_CLEAR) && i_wdata[`IRQ_BIT_OVERFLOW]));
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      irq_en_q <= 2'h0;
    end
    else if (i_wr && (i_addr == `OFS_IRQ_ENABLE))
    begin
      irq_en_q <= i_wdata[1:0];
    end
  end

  assign o_irq = |(irq_stat_q & irq_en_q);

  // ******************************************************************
  // read port
  // ******************************************************************
  // unmapped and write-only offsets read as zero
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rst)
    begin
      rdata_q <= 16'h0000;
    end
    else if (i_rd)
    begin
      case (i_addr)
        `OFS_HOST_PORT_CTRL_TWO:      rdata_q <= ctrl_two_q;
        `OFS_HOST_PORT_VLAN_ID_CTRL:  rdata_q <= vlan_id_q;
        `OFS_HOST_PORT_CTRL_THREE:    rdata_q <= ctrl_three_q;
        `OFS_HOST_PORT_INGRESS_RATE:  rdata_q <= ingress_q;
        `OFS_HOST_PORT_EGRESS_RATE:   rdata_q <= egress_q;
        `OFS_BANK_SELECT:             rdata_q <= bank_q;
        `OFS_INDIRECT_ACCESS_CTRL:    rdata_q <= {6'h00, ind_addr_q};
        `OFS_INDIRECT_DATA_LOW_HALF:  rdata_q <= snap_q[15:0];  // [R14]
        `OFS_INDIRECT_DATA_HIGH_HALF: rdata_q <= snap_q[31:16]; // [R14]
        `OFS_IRQ_STATUS:              rdata_q <= {14'h0000, irq_stat_q};
        `OFS_IRQ_ENABLE:              rdata_q <= {14'h0000, irq_en_q};
        default:                      rdata_q <= 16'h0000;
      endcase
    end
    else
    begin
      rdata_q <= 16'h0000;
    end
  end
  assign o_rdata = rdata_q;

  // ******************************************************************
  // checks
  // ******************************************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  a_learn_ctrl: assert property (wr_ctrl_two |=> // [R1]
    o_learn_enable == !$past(i_wdata[`BIT_LEARN_DISABLE]))
    else $error("learning enable does not follow control write");

  a_rx_mark: assert property ((i_rx_pkt && ctrl_two_q[`BIT_RX_SNIFF]) // [R3]
    |=> o_rx_monitored)
    else $error("received packet not marked monitored");

  a_tx_mark: assert property ((!i_tx_pkt || !ctrl_two_q[`BIT_TX_SNIFF]) // [R4]
    |=> !o_tx_monitored)
    else $error("transmit packet marked without sniff");

  a_prio_cap: assert property ((ctrl_two_q[`BIT_PRIO_CEILING] && // [R5]
    (i_pkt_prio > i_default_prio)) |=> o_pkt_prio == $past(i_default_prio))
    else $error("priority ceiling not applied");

  a_fwd_member: assert property (##1 (o_fwd_mask & // [R7]
    ~$past(ctrl_two_q[2:0])) == 3'h0)
    else $error("forwarding reached a non-member port");

  a_read_clear: assert property ((rd_trigger && in_window && // [R11]
    !i_cnt_inc[rd_idx]) |=> cnt_q[$past(rd_idx)] == 30'h0 && !ovf_q[$past(rd_idx)])
    else $error("counter not cleared by read");

  a_snap_pair: assert property (rd_trigger |=> // [R15]
    snap_q == $past(word_now))
    else $error("snapshot not taken from the addressed counter");

  // control writes may come back to back, so the hold is checked per cycle
  a_snap_hold: assert property (!rd_trigger |=> $stable(snap_q)) // [R15]
    else $error("snapshot halves not held together");

  a_low_half: assert property ((i_rd && i_addr == `OFS_INDIRECT_DATA_LOW_HALF // [R14]
    && !rd_trigger) |=> o_rdata == snap_q[15:0])
    else $error("low half read returns wrong data");

  a_window_valid: assert property ((rd_trigger && !in_window) |=> // [R10]
    snap_q.valid == 1'b0 && snap_q.count == 30'h0)
    else $error("out of window read reported valid");

  a_mirror_ctrl: assert property (wr_ctrl_two |=> // [R2]
    o_mirror_dest == $past(i_wdata[`BIT_MIRROR_DEST]))
    else $error("mirror destination does not follow control write");

  a_rx_quiet: assert property ((!i_rx_pkt || !ctrl_two_q[`BIT_RX_SNIFF]) // [R3]
    |=> !o_rx_monitored)
    else $error("receive packet marked without sniff");

  a_tx_mark_on: assert property ((i_tx_pkt && ctrl_two_q[`BIT_TX_SNIFF]) // [R4]
    |=> o_tx_monitored)
    else $error("transmit packet not marked monitored");

  a_read_done_set: assert property (rd_trigger |=> // [R14]
    irq_stat_q[`IRQ_BIT_READ_DONE])
    else $error("read done status not set");

  // read data must not linger, software may sample any cycle
  a_rdata_idle: assert property (!i_rd |=> o_rdata == 16'h0000) // [R14]
    else $error("read data outside its cycle");

  c_counter_read: cover property (rd_trigger && in_window && rd_idx >= 6'h20);
  c_read_with_inc: cover property (rd_trigger && in_window && i_cnt_inc[rd_idx]);
  c_irq_raised: cover property (!o_irq ##1 o_irq);
  c_rx_mirrored: cover property (o_rx_monitored);
  c_prio_capped: cover property (ctrl_two_q[`BIT_PRIO_CEILING] &&
    (i_pkt_prio > i_default_prio));

endmodule : switch_port_ctrl_mib_readout
`default_nettype wire

/* sim/host_bus_model.sv */
// host software model: drives the plain register port of the block
// assumes one clock and a slave that never stalls
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
(
  input  wire logic                               i_sys_clk,
  input  wire switch_port_ctrl_pkg::reg16_type    i_rdata,
  output logic                                    o_wr,
  output logic                                    o_rd,
  output var switch_port_ctrl_pkg::reg_addr_type  o_addr,
  output var switch_port_ctrl_pkg::reg16_type     o_wdata
);
  import switch_port_ctrl_pkg::*;

  initial
  begin
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_addr  = 8'h00;
    o_wdata = 16'h0000;
  end

  // idle bus shows inverted values, so a decoder that ignores strobes is caught
  task automatic write_reg(input reg_addr_type a, input reg16_type d);
    @(posedge i_sys_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_sys_clk);
    o_wr    <= 1'b0;
    o_addr  <= ~a;
    o_wdata <= ~d;
  endtask : write_reg

  // data stands only in the cycle after the strobe
  task automatic read_reg(input reg_addr_type a, output reg16_type d);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_sys_clk);
    o_rd   <= 1'b0;
    o_addr <= ~a;
    #1;
    d = i_rdata;
  endtask : read_reg
endmodule : host_bus_model
`default_nettype wire

/* sim/switch_port_ctrl_mib_readout_bench.sv */
// self-checking bench for the host-port control and statistics readout block
// assumes the host model drives the register port; bench drives packet pins
`timescale 1ns/1ps
`include "switch_port_ctrl_defines.svh"
`default_nettype none
module switch_port_ctrl_mib_readout_bench;
  import switch_port_ctrl_pkg::*;

  typedef struct packed {
    reg16_type  ctrl;
    logic       rx;
    logic       tx;
    logic [2:0] pprio;
    logic [2:0] dprio;
    logic [2:0] req;
    logic [9:0] exp;
  } row_type;

  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic [63:0]  cnt_inc = '0;
  logic         rx = 1'b0;
  logic         tx = 1'b0;
  logic [2:0]   pprio = 3'h0;
  logic [2:0]   dprio = 3'h0;
  logic [2:0]   req = 3'h0;
  logic         wr;
  logic         rd;
  reg_addr_type addr;
  reg16_type    wdata;
  reg16_type    rdata;
  reg16_type    d;
  wire logic    irq;
  wire logic [9:0] pins;
  wire logic [9:0] o_misc;
  int           fail_count = 0;
  int           compares = 0;
  row_type      rows [4];

  always #2 clk = ~clk;

  host_bus_model host_u (.i_sys_clk(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd),
                         .o_addr(addr), .o_wdata(wdata));

  switch_port_ctrl_mib_readout dut_u (
    .i_sys_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_cnt_inc(cnt_inc), .i_rx_pkt(rx), .i_tx_pkt(tx),
    .i_pkt_prio(pprio), .i_default_prio(dprio), .i_fwd_req(req),
    .o_learn_enable(o_misc[9]), .o_mirror_dest(o_misc[8]), .o_rx_monitored(o_misc[7]),
    .o_tx_monitored(o_misc[6]), .o_pkt_prio(o_misc[5:3]), .o_fwd_mask(o_misc[2:0]),
    .o_irq(irq));

  assign pins = o_misc;

  // ************************************************************
  // compare and closing tasks
  // ************************************************************
  task automatic chk_reg(input reg16_type got, input reg16_type exp);
    compares++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: register %h, want %h", $time, got, exp);
      fail_count++;
    end
  endtask : chk_reg

  task automatic chk_pins(input logic [9:0] got, input logic [9:0] exp);
    compares++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: pins %b, want %b", $time, got, exp);
      fail_count++;
    end
  endtask : chk_pins

  task automatic results;
    $display("comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  task automatic bump(input int idx, input int n);
    @(posedge clk);
    cnt_inc[idx] <= 1'b1;
    repeat (n) @(posedge clk);
    cnt_inc <= '0;
  endtask : bump

  // one snapshot read, checked as two halves
  task automatic ind_read(input logic [9:0] idx, input logic [31:0] exp);
    host_u.write_reg(`OFS_INDIRECT_ACCESS_CTRL, 16'h1000 | {6'h00, idx});
    host_u.read_reg(`OFS_INDIRECT_DATA_LOW_HALF, d);
    chk_reg(d, exp[15:0]); // low half
    host_u.read_reg(`OFS_INDIRECT_DATA_HIGH_HALF, d);
    chk_reg(d, exp[31:16]); // high half with flags
  endtask : ind_read

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    results();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    rows[0] = '{16'h0607, 1'b1, 1'b1, 3'h5, 3'h2, 3'h7, 10'b1000_101_111};
    rows[1] = '{16'h07e8, 1'b1, 1'b1, 3'h5, 3'h2, 3'h7, 10'b0111_010_000};
    rows[2] = '{16'h0649, 1'b1, 1'b0, 3'h1, 3'h4, 3'h7, 10'b1010_001_001};
    rows[3] = '{16'h0626, 1'b0, 1'b1, 3'h6, 3'h3, 3'h3, 10'b1001_110_010};
    repeat (2) @(posedge clk);
    #1;
    chk_pins(pins, 10'b1000_000_000); // reset levels
    @(posedge clk);
    rst <= 1'b0;
    host_u.read_reg(`OFS_HOST_PORT_CTRL_TWO, d);
    chk_reg(d, 16'h0607); // reset value
    for (int i = 0; i < 4; i++)
    begin
      host_u.write_reg(`OFS_HOST_PORT_CTRL_TWO, rows[i].ctrl);
      host_u.read_reg(`OFS_HOST_PORT_CTRL_TWO, d);
      chk_reg(d, rows[i].ctrl); // readback
      @(posedge clk);
      rx    <= rows[i].rx;
      tx    <= rows[i].tx;
      pprio <= rows[i].pprio;
      dprio <= rows[i].dprio;
      req   <= rows[i].req;
      @(posedge clk);
      rx <= 1'b0;
      tx <= 1'b0;
      #1;
      chk_pins(pins, rows[i].exp);
    end
    // window edges of both ports
    bump(0, 3);
    bump(31, 2);
    bump(32, 5);
    bump(63, 1);
    ind_read(10'h000, 32'h4000_0003); // first port base
    ind_read(10'h000, 32'h4000_0000); // cleared by read
    ind_read(10'h01f, 32'h4000_0002); // first port top
    ind_read(10'h020, 32'h4000_0005); // second port base
    ind_read(10'h03f, 32'h4000_0001); // second port top
    ind_read(10'h040, 32'h0000_0000); // beyond both windows
    // interrupt raised, cleared, masked
    host_u.write_reg(`OFS_IRQ_ENABLE, 16'h0001);
    ind_read(10'h005, 32'h4000_0000);
    chk_pins({irq, 9'h000}, 10'h200);
    host_u.read_reg(`OFS_IRQ_STATUS, d);
    chk_reg(d, 16'h0001);
    host_u.write_reg(`OFS_IRQ_CLEAR, 16'h0001);
    #1;
    chk_pins({irq, 9'h000}, 10'h000);
    host_u.write_reg(`OFS_IRQ_ENABLE, 16'h0000);
    ind_read(10'h005, 32'h4000_0000);
    chk_pins({irq, 9'h000}, 10'h000);
    host_u.read_reg(`OFS_IRQ_STATUS, d);
    chk_reg(d, 16'h0001);
    host_u.read_reg(`OFS_IRQ_CLEAR, d);
    chk_reg(d, 16'h0000);
    host_u.read_reg(8'h30, d);
    chk_reg(d, 16'h0000);
    host_u.read_reg(`OFS_INDIRECT_ACCESS_CTRL, d);
    chk_reg(d, 16'h0005); // start bit not stored
    host_u.write_reg(`OFS_HOST_PORT_CTRL_TWO, 16'hffff);
    host_u.read_reg(`OFS_HOST_PORT_CTRL_TWO, d);
    chk_reg(d, 16'h67ff); // reserved bits read zero
    // reset in mid-run clears control and counters
    host_u.write_reg(`OFS_HOST_PORT_CTRL_TWO, 16'h07e8);
    bump(2, 4);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_pins(pins, 10'b1000_000_000);
    @(posedge clk);
    rst <= 1'b0;
    host_u.read_reg(`OFS_HOST_PORT_CTRL_TWO, d);
    chk_reg(d, 16'h0607);
    ind_read(10'h002, 32'h4000_0000);
    results();
  end
endmodule : switch_port_ctrl_mib_readout_bench
`default_nettype wire
